/* File: hw/nac_pkg.sv */
// constants and types shared by the nonvolatile access control block
package nac_pkg;
  // ==========================================
  // register bus
  localparam int ADDR_W = 3;
  localparam int DATA_W = 8;
  localparam int PTR_W  = 16;
  localparam logic [ADDR_W-1:0] ADDR_CTRL    = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_WDATA   = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_RDATA   = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_PTR_LO  = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_PTR_HI  = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ST  = 3'h5;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MSK = 3'h6;
  // ==========================================
  // control register field positions
  localparam int BIT_CODE   = 7;
  localparam int BIT_SETUP  = 6;
  localparam int BIT_UNUSED = 5;
  localparam int BIT_ERASE  = 4;
  localparam int BIT_FAULT  = 3;
  localparam int BIT_PERMIT = 2;
  localparam int BIT_WR     = 1;
  localparam int BIT_RD     = 0;
  localparam logic [DATA_W-1:0] RD_ZERO = 8'h00;
  // ==========================================
  // interrupt status field positions
  localparam int IRQ_W       = 3;
  localparam int IRQ_DONE    = 0;
  localparam int IRQ_FAULT   = 1;
  localparam int IRQ_RD_DONE = 2;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  // ==========================================
  // self-timed cycle length
  localparam int CLK_MHZ      = 50;
  localparam int PROG_TIME_US = 2;
  localparam int PROG_CYCLES  = PROG_TIME_US * CLK_MHZ;
  // ==========================================
  // access target seen by the arrays
  typedef enum logic [1:0] {
    NAC_TGT_EEPROM,
    NAC_TGT_FLASH,
    NAC_TGT_SETUP
  } nac_target_t;
endpackage

/* File: hw/nac_cyc_if.sv */
// handshake between the control logic and the cycle timer
`timescale 1ns/1ps
`default_nettype none
interface nac_cyc_if;
  logic start;
  logic done;
  logic busy;
  modport ctl (output start, input done, input busy);
  modport tmr (input start, output done, output busy);
endinterface
`default_nettype wire

/* File: hw/nac_cycle_timer.sv */
// timer for self-timed erase and write cycles
`timescale 1ns/1ps
`default_nettype none
module nac_cycle_timer #(
  parameter int CYCLE_LEN = 100
) (
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  nac_cyc_if.tmr    cyc
);
  import nac_pkg::*;

  logic [15:0] cnt_reg;
  logic        busy_reg;
  logic        last;

  // last cycle of the count
  assign last     = busy_reg && (cnt_reg == 16'(CYCLE_LEN - 1));
  assign cyc.done = last;
  assign cyc.busy = busy_reg;

  // busy flag
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      busy_reg <= 1'b0;
    end else if (cyc.start) begin
      busy_reg <= 1'b1;
    end else if (last) begin
      busy_reg <= 1'b0;
    end
  end

  // cycle counter
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || cyc.start) begin
      cnt_reg <= 16'h0000;
    end else if (busy_reg && !last) begin
      cnt_reg <= cnt_reg + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* File: hw/nac_irq_ctrl.sv */
// sticky event flags, mask and interrupt output
`timescale 1ns/1ps
`default_nettype none
module nac_irq_ctrl (
  input  wire logic                      mclk_in,
  input  wire logic                      sys_rst_in,
  input  wire logic [nac_pkg::IRQ_W-1:0] event_in,
  input  wire logic                      st_wr_in,
  input  wire logic                      msk_wr_in,
  input  wire logic [nac_pkg::IRQ_W-1:0] wdata_in,
  output logic      [nac_pkg::IRQ_W-1:0] status_out,
  output logic      [nac_pkg::IRQ_W-1:0] mask_out,
  output logic                           irq_out
);
  import nac_pkg::*;

  // status: write one clears, a new event wins over the clear
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      status_out <= IRQ_RST;
    end else begin
      status_out <= (status_out & ~(st_wr_in ? wdata_in : IRQ_RST)) | event_in;
    end
  end

  // mask register
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      mask_out <= IRQ_RST;
    end else if (msk_wr_in) begin
      mask_out <= wdata_in;
    end
  end

  assign irq_out = |(status_out & mask_out);
endmodule
`default_nettype wire

/* File: hw/nac_access_ctrl.sv */
// nonvolatile access control register and cycle sequencing
// Operation
// - code select high routes accesses to program flash, low to data EEPROM, while setup select is low.
// - setup select high routes accesses to configuration space.
// - control bit 5 reads zero and ignores writes.
// - erase arm makes the next program flash cycle a row erase; cleared on completion.
// - fault flag set by reset during a cycle or improper write attempt.
// - erase and write cycles start only while program permit is set.
// - program trigger starts a self-timed cycle, cleared by hardware when done.
// - software can only set the program trigger, never clear it.
// - read trigger starts a one-cycle read, then hardware clears it.
// - read trigger refused while code select or setup select is set.
// - a reset cutting a cycle short leaves both select bits unchanged on its first edge, for tracing.
`timescale 1ns/1ps
`default_nettype none
module nac_access_ctrl #(
  parameter int CYCLE_LEN = nac_pkg::PROG_CYCLES
) (
  input  wire logic                       mclk_in,
  input  wire logic                       sys_rst_in,
  input  wire logic [nac_pkg::ADDR_W-1:0] addr_in,
  input  wire logic [nac_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                       wr_stb_in,
  input  wire logic                       rd_stb_in,
  output logic      [nac_pkg::DATA_W-1:0] rdata_out,
  output logic                            irq_out,
  output nac_pkg::nac_target_t            nvm_target_out,
  output logic      [nac_pkg::PTR_W-1:0]  nvm_addr_out,
  output logic      [nac_pkg::DATA_W-1:0] nvm_wdata_out,
  output logic                            nvm_prog_start_out,
  output logic                            nvm_prog_busy_out,
  output logic                            nvm_erase_out,
  output logic                            nvm_rd_stb_out,
  input  wire logic [nac_pkg::DATA_W-1:0] nvm_rdata_in
);
  import nac_pkg::*;

  // ==========================================
  // storage
  logic                code_sel_reg;
  logic                setup_sel_reg;
  logic                erase_arm_reg;
  logic                fault_reg;
  logic                permit_reg;
  logic                wr_reg;
  logic                rd_reg;
  logic [DATA_W-1:0]   wdata_reg;
  logic [DATA_W-1:0]   rdata_reg;
  logic [PTR_W-1:0]    ptr_reg;
  logic [IRQ_W-1:0]    irq_status;
  logic [IRQ_W-1:0]    irq_mask;
  logic [IRQ_W-1:0]    irq_event;
  logic [DATA_W-1:0]   ctrl_val;
  logic [DATA_W-1:0]   rdata_next;
  logic                ctrl_wr;
  logic                wr_go;
  logic                wr_bad;
  logic                wr_start;
  logic                rd_go;

  nac_cyc_if cyc ();

  // ==========================================
  // control write decode
  assign ctrl_wr  = wr_stb_in && (addr_in == ADDR_CTRL);
  assign wr_go    = ctrl_wr && wdata_in[BIT_WR] && !wr_reg;
  assign wr_bad   = wr_go && !permit_reg;
  assign wr_start = wr_go && permit_reg;
  assign rd_go    = ctrl_wr && wdata_in[BIT_RD] && !rd_reg && !wr_reg
                    && !wdata_in[BIT_CODE] && !wdata_in[BIT_SETUP];
  assign cyc.start = wr_start;

  // control image, bit 5 always zero
  assign ctrl_val = {code_sel_reg, setup_sel_reg, 1'b0, erase_arm_reg,
                     fault_reg, permit_reg, wr_reg, rd_reg};

  // ==========================================
  // select bits, frozen during a cycle and on the first edge of a faulting reset
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      if (!wr_reg) begin
        code_sel_reg  <= 1'b0;
        setup_sel_reg <= 1'b0;
      end
    end else if (ctrl_wr && !wr_reg) begin
      code_sel_reg  <= wdata_in[BIT_CODE];
      setup_sel_reg <= wdata_in[BIT_SETUP];
    end
  end

  // row erase arm
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      erase_arm_reg <= 1'b0;
    end else if (cyc.done) begin
      erase_arm_reg <= 1'b0;
    end else if (ctrl_wr && !wr_reg) begin
      erase_arm_reg <= wdata_in[BIT_ERASE];
    end
  end

  // fault flag: a reset that cuts a cycle short leaves it set
  // only the first reset edge still sees the running trigger;
  // a reset held longer clears the flag and selects on its second edge
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      fault_reg <= wr_reg;
    end else if (wr_bad) begin
      fault_reg <= 1'b1;
    end else if (cyc.done) begin
      fault_reg <= 1'b0;
    end else if (ctrl_wr) begin
      fault_reg <= wdata_in[BIT_FAULT];
    end
  end

  // program permit
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      permit_reg <= 1'b0;
    end else if (ctrl_wr) begin
      permit_reg <= wdata_in[BIT_PERMIT];
    end
  end

  // program trigger, held until the timer expires
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wr_reg <= 1'b0;
    end else if (wr_start) begin
      wr_reg <= 1'b1;
    end else if (cyc.done) begin
      wr_reg <= 1'b0;
    end
  end

  // read trigger, one cycle long
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rd_reg <= 1'b0;
    end else begin
      rd_reg <= rd_go;
    end
  end

  // ==========================================
  // data and pointer registers
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      wdata_reg <= RD_ZERO;
    end else if (wr_stb_in && (addr_in == ADDR_WDATA) && !wr_reg) begin
      wdata_reg <= wdata_in;
    end
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      ptr_reg <= '0;
    end else if (wr_stb_in && !wr_reg && (addr_in == ADDR_PTR_LO)) begin
      ptr_reg[DATA_W-1:0] <= wdata_in;
    end else if (wr_stb_in && !wr_reg && (addr_in == ADDR_PTR_HI)) begin
      ptr_reg[PTR_W-1:DATA_W] <= wdata_in;
    end
  end

  // array read data captured while the read strobe is out
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rdata_reg <= RD_ZERO;
    end else if (rd_reg) begin
      rdata_reg <= nvm_rdata_in;
    end
  end

  // ==========================================
  // array side outputs
  always_comb begin
    if (setup_sel_reg) begin
      nvm_target_out = NAC_TGT_SETUP;
    end else if (code_sel_reg) begin
      nvm_target_out = NAC_TGT_FLASH;
    end else begin
      nvm_target_out = NAC_TGT_EEPROM;
    end
  end

  assign nvm_addr_out       = ptr_reg;
  assign nvm_wdata_out      = wdata_reg;
  assign nvm_prog_start_out = wr_start;
  assign nvm_prog_busy_out  = wr_reg;
  assign nvm_erase_out      = erase_arm_reg && code_sel_reg && !setup_sel_reg;
  assign nvm_rd_stb_out     = rd_reg;

  // ==========================================
  // register read port
  always_comb begin
    case (addr_in)
      ADDR_CTRL:    rdata_next = ctrl_val;
      ADDR_WDATA:   rdata_next = wdata_reg;
      ADDR_RDATA:   rdata_next = rdata_reg;
      ADDR_PTR_LO:  rdata_next = ptr_reg[DATA_W-1:0];
      ADDR_PTR_HI:  rdata_next = ptr_reg[PTR_W-1:DATA_W];
      ADDR_IRQ_ST:  rdata_next = {{(DATA_W-IRQ_W){1'b0}}, irq_status};
      ADDR_IRQ_MSK: rdata_next = {{(DATA_W-IRQ_W){1'b0}}, irq_mask};
      default:      rdata_next = RD_ZERO;
    endcase
  end

  always_ff @(posedge mclk_in) begin
    if (sys_rst_in) begin
      rdata_out <= RD_ZERO;
    end else if (rd_stb_in) begin
      rdata_out <= rdata_next;
    end else begin
      rdata_out <= RD_ZERO;
    end
  end

  // ==========================================
  // submodules
  nac_cycle_timer #(.CYCLE_LEN(CYCLE_LEN)) u_timer (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .cyc        (cyc.tmr)
  );

  assign irq_event = {rd_reg, wr_bad, cyc.done};

  nac_irq_ctrl u_irq (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .event_in   (irq_event),
    .st_wr_in   (wr_stb_in && (addr_in == ADDR_IRQ_ST)),
    .msk_wr_in  (wr_stb_in && (addr_in == ADDR_IRQ_MSK)),
    .wdata_in   (wdata_in[IRQ_W-1:0]),
    .status_out (irq_status),
    .mask_out   (irq_mask),
    .irq_out    (irq_out)
  );

  // ==========================================
  // checks
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);

  logic [15:0] ast_len_reg;
  always_ff @(posedge mclk_in) begin
    if (sys_rst_in || !wr_reg) begin
      ast_len_reg <= 16'h0000;
    end else begin
      ast_len_reg <= ast_len_reg + 16'h0001;
    end
  end

  sequence s_rd_pulse;
    rd_reg ##1 !rd_reg;
  endsequence

  // routing follows the stored select bits
  AST_FLASH_ROUTE: assert property (
    code_sel_reg && !setup_sel_reg |-> nvm_target_out == NAC_TGT_FLASH)
    else $error("flash not selected");
  AST_EEPROM_ROUTE: assert property (
    !code_sel_reg && !setup_sel_reg |-> nvm_target_out == NAC_TGT_EEPROM)
    else $error("eeprom not selected");
  AST_SETUP_ROUTE: assert property (
    setup_sel_reg |-> nvm_target_out == NAC_TGT_SETUP)
    else $error("setup space not selected");
  AST_BIT5_ZERO: assert property (
    rd_stb_in && addr_in == ADDR_CTRL |=> rdata_out[BIT_UNUSED] == 1'b0)
    else $error("bit 5 read nonzero");
  // erase arm only reaches program flash and ends with the cycle
  AST_ERASE_CLEAR: assert property (
    cyc.done |=> !erase_arm_reg)
    else $error("erase arm kept");
  AST_ERASE_FLASH: assert property (
    nvm_erase_out |-> nvm_target_out == NAC_TGT_FLASH)
    else $error("erase outside program flash");
  AST_FAULT_SET: assert property (
    wr_bad |=> fault_reg && !wr_reg && irq_status[IRQ_FAULT])
    else $error("improper write not flagged");
  AST_PERMIT: assert property (
    $rose(wr_reg) |-> $past(permit_reg))
    else $error("cycle without permit");
  // trigger: set by software, cleared only by the timer
  AST_TRIG_HOLD: assert property (
    wr_reg && !cyc.done |=> wr_reg)
    else $error("trigger dropped early");
  AST_TRIG_END: assert property (
    cyc.done |=> !wr_reg && irq_status[IRQ_DONE])
    else $error("trigger not cleared");
  AST_RD_PULSE: assert property (
    rd_go |=> s_rd_pulse)
    else $error("read trigger not one cycle");
  AST_RD_REFUSE: assert property (
    ctrl_wr && (wdata_in[BIT_CODE] || wdata_in[BIT_SETUP]) |=> !rd_reg)
    else $error("read set with select high");
  // selects stay put on a fault and while a cycle runs
  AST_SEL_KEEP: assert property (
    fault_reg && !ctrl_wr |=> $stable(code_sel_reg) && $stable(setup_sel_reg))
    else $error("select lost on fault");
  AST_SEL_FROZEN: assert property (
    wr_reg |=> $stable(code_sel_reg) && $stable(setup_sel_reg))
    else $error("select changed during cycle");
  // a reset-cut cycle is not a completed one, so it is left out
  AST_CYCLE_LEN: assert property (
    $fell(wr_reg) && !$past(sys_rst_in) |-> ast_len_reg == 16'(CYCLE_LEN))
    else $error("cycle length wrong");
  AST_BUSY_MATCH: assert property (
    cyc.busy == wr_reg)
    else $error("timer busy and trigger disagree");
endmodule
`default_nettype wire

/* File: verification/nac_nvm_model.sv */
// behavioural model of the flash and eeprom arrays behind the access control
`timescale 1ns/1ps
`default_nettype none
module nac_nvm_model (
  input  wire logic                       mclk_in,
  input  wire nac_pkg::nac_target_t       target_in,
  input  wire logic [nac_pkg::PTR_W-1:0]  addr_in,
  input  wire logic [nac_pkg::DATA_W-1:0] wdata_in,
  input  wire logic                       start_in,
  input  wire logic                       erase_in,
  input  wire logic                       rd_stb_in,
  output logic      [nac_pkg::DATA_W-1:0] rdata_out
);
  import nac_pkg::*;
  logic [7:0] ee_mem [256];
  logic [7:0] fl_mem [256];
  logic [7:0] last_q;
  // ==========================================
  // preset contents, eeprom a pattern of the index, flash all zero
  initial begin
    last_q = 8'h00;
    for (int i = 0; i < 256; i++) begin
      ee_mem[i] = 8'(i) ^ 8'hA5;
      fl_mem[i] = 8'h00;
    end
  end
  // ==========================================
  // program cycle: eeprom write, flash write or row erase
  always @(posedge mclk_in) begin
    if (start_in && target_in == NAC_TGT_EEPROM) begin
      ee_mem[addr_in[7:0]] <= wdata_in;
    end
    if (start_in && target_in == NAC_TGT_FLASH) begin
      fl_mem[addr_in[7:0]] <= erase_in ? 8'hFF : wdata_in;
    end
    if (rd_stb_in) begin
      last_q <= rdata_out;
    end
  end
  // one-cycle read; outside it the line shows the inverse of the last value
  assign rdata_out = (rd_stb_in && target_in == NAC_TGT_EEPROM) ?
                     ee_mem[addr_in[7:0]] : ~last_q;
endmodule
`default_nettype wire

/* File: verification/nvm_access_control_tb.sv */
// self-checking testbench for the nonvolatile access control block
`timescale 1ns/1ps
`default_nettype none
module nvm_access_control_tb;
  import nac_pkg::*;
  localparam int CL = 8;
  logic mclk_in, sys_rst_in, wr_stb, rd_stb, irq, start, busy, erase, nrd;
  logic [2:0] addr;
  logic [7:0] wdata, rdata, nwd, nrdata, v;
  logic [15:0] naddr;
  nac_target_t tgt;
  int n_fail, samples_checked, busy_cnt, st_cnt;
  nac_access_ctrl #(.CYCLE_LEN(CL)) dut (
    .mclk_in(mclk_in), .sys_rst_in(sys_rst_in), .addr_in(addr), .wdata_in(wdata),
    .wr_stb_in(wr_stb), .rd_stb_in(rd_stb), .rdata_out(rdata), .irq_out(irq),
    .nvm_target_out(tgt), .nvm_addr_out(naddr), .nvm_wdata_out(nwd),
    .nvm_prog_start_out(start), .nvm_prog_busy_out(busy), .nvm_erase_out(erase),
    .nvm_rd_stb_out(nrd), .nvm_rdata_in(nrdata));
  nac_nvm_model arr (
    .mclk_in(mclk_in), .target_in(tgt), .addr_in(naddr), .wdata_in(nwd),
    .start_in(start), .erase_in(erase), .rd_stb_in(nrd), .rdata_out(nrdata));
  // ==========================================
  // clock and cycle monitors
  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  always @(posedge mclk_in) begin
    if (busy === 1'b1) busy_cnt++;
    if (start === 1'b1) st_cnt++;
  end
  // ==========================================
  // bus tasks and comparison
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk_in);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge mclk_in);
    wr_stb <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    @(posedge mclk_in);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge mclk_in);
    rd_stb <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [7:0] exp);
    rd(a, v);
    check(v, exp);
  endtask
  task automatic wait_idle;
    for (int i = 0; i < 50 && busy !== 1'b0; i++) @(posedge mclk_in);
    #1;
  endtask
  task automatic wrap_up;
    $display("checks=%0d mismatches=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // watchdog
  initial begin
    repeat (5000) @(posedge mclk_in);
    n_fail++;
    wrap_up();
  end
  // ==========================================
  // main sequence
  initial begin
    n_fail = 0; samples_checked = 0; busy_cnt = 0; st_cnt = 0;
    sys_rst_in = 1'b1; wr_stb = 1'b0; rd_stb = 1'b0; addr = 3'h0; wdata = 8'h00;
    repeat (4) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rchk(ADDR_CTRL, 8'h00);
    rchk(3'h7, 8'h00);
    // select bits, unused bit and target routing
    wr(ADDR_CTRL, 8'hE0);
    check({6'h0, tgt}, 8'h02);
    rchk(ADDR_CTRL, 8'hC0);
    wr(ADDR_CTRL, 8'h80);
    check({6'h0, tgt}, 8'h01);
    wr(ADDR_CTRL, 8'h81);
    rchk(ADDR_CTRL, 8'h80);
    wr(ADDR_CTRL, 8'h41);
    check({7'h0, nrd}, 8'h00);
    wr(ADDR_CTRL, 8'h00);
    check({6'h0, tgt}, 8'h00);
    // trigger without permit is refused and flagged
    wr(ADDR_CTRL, 8'h02);
    check(8'(st_cnt), 8'h00);
    rchk(ADDR_CTRL, 8'h08);
    // eeprom write cycle, timed, trigger cannot be cleared
    wr(ADDR_PTR_LO, 8'h12);
    wr(ADDR_PTR_HI, 8'h00);
    wr(ADDR_WDATA, 8'h5A);
    wr(ADDR_CTRL, 8'h04);
    busy_cnt = 0;
    wr(ADDR_CTRL, 8'h06);
    check({7'h0, busy}, 8'h01);
    wr(ADDR_CTRL, 8'h04);
    rchk(ADDR_CTRL, 8'h06);
    wr(ADDR_WDATA, 8'h33);
    wait_idle();
    check(8'(busy_cnt), 8'(CL));
    check(8'(st_cnt), 8'h01);
    rchk(ADDR_CTRL, 8'h04);
    rchk(ADDR_WDATA, 8'h5A);
    rchk(ADDR_PTR_LO, 8'h12);
    // eeprom read returns the byte just written
    wr(ADDR_CTRL, 8'h05);
    check({7'h0, nrd}, 8'h01);
    rchk(ADDR_CTRL, 8'h04);
    rchk(ADDR_RDATA, 8'h5A);
    // flash row erase clears the arm bit on completion
    wr(ADDR_CTRL, 8'h94);
    check({7'h0, erase}, 8'h01);
    wr(ADDR_CTRL, 8'h96);
    wait_idle();
    rchk(ADDR_CTRL, 8'h84);
    // interrupt status, mask and clear
    rchk(ADDR_IRQ_ST, 8'h07);
    check({7'h0, irq}, 8'h00);
    wr(ADDR_IRQ_MSK, 8'h02);
    check({7'h0, irq}, 8'h01);
    wr(ADDR_IRQ_ST, 8'h02);
    check({7'h0, irq}, 8'h00);
    rchk(ADDR_IRQ_ST, 8'h05);
    wr(ADDR_IRQ_MSK, 8'h05);
    check({7'h0, irq}, 8'h01);
    wr(ADDR_IRQ_ST, 8'h05);
    check({7'h0, irq}, 8'h00);
    // reset in mid-cycle flags a fault and keeps the selects
    wr(ADDR_CTRL, 8'hC4);
    wr(ADDR_CTRL, 8'hC6);
    @(posedge mclk_in);
    sys_rst_in <= 1'b1;
    @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    rchk(ADDR_CTRL, 8'hC8);
    check({6'h0, tgt}, 8'h02);
    wrap_up();
  end
endmodule
`default_nettype wire
